// [verilog/ifeb_bank.sv]
// Purpose: Interrupt request flag and enable bank with Avalon-MM access.
// Assumes: Single clock; event inputs are one-cycle pulses.
// Notes:   Vector requests are flag AND enable AND global enable.
//
// Design decisions made here: the Avalon-MM register port and the address map.

`timescale 1ns/10ps
`default_nettype none

module ifeb_bank #(
	parameter int HAS_UART    = 1,
	parameter int HAS_PTIMER1 = 1
) (
	input  wire logic                          clk_in,
	input  wire logic                          rst_n_in,
	input  wire logic [ifeb_pkg::ADDR_W-1:0]   avs_address_in,
	input  wire logic                          avs_read_in,
	input  wire logic                          avs_write_in,
	input  wire logic [31:0]                   avs_writedata_in,
	input  wire logic [3:0]                    avs_byteenable_in,
	output logic      [31:0]                   avs_readdata_out,
	output logic                               avs_waitrequest_out,
	input  wire ifeb_pkg::ifeb_src_t           evt_in,
	input  wire logic                          svc_ack_in,
	output ifeb_pkg::ifeb_src_t                vec_req_out,
	output logic                               irq_out
);

	// ************************************************
	// Elaboration checks and implemented-bit mask
	// ************************************************
	if (HAS_UART < 0 || HAS_UART > 1) begin : g_chk_uart
		$error("HAS_UART must be 0 or 1");
	end
	if (HAS_PTIMER1 < 0 || HAS_PTIMER1 > 1) begin : g_chk_pt1
		$error("HAS_PTIMER1 must be 0 or 1");
	end

	localparam logic HAS_U  = 1'(HAS_UART);
	localparam logic HAS_P1 = 1'(HAS_PTIMER1);
	// Unimplemented slots are held at zero here
	localparam logic [15:0] IMPL = {HAS_P1, HAS_P1, 2'b11,
		2'b00, HAS_U, 1'b1, 8'hFF};

	if (ifeb_pkg::GROUP_W * ifeb_pkg::NUM_GROUPS != 16) begin : g_chk_w
		$error("group layout must fill 16 source bits");
	end

	// ************************************************
	// State
	// ************************************************
	logic [15:0] flag_q;
	logic [15:0] flag_d;
	logic [15:0] en_q;
	logic [15:0] en_d;
	logic        gen_q;
	logic        gen_d;
	logic [3:0]  sts_q;
	logic [3:0]  sts_d;
	logic [3:0]  msk_q;
	logic [3:0]  msk_d;
	logic        done_q;
	logic        done_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// ************************************************
	// Bus decode
	// ************************************************
	localparam logic [31:0] RD_ZERO = ifeb_pkg::RD_RESET;

	logic        req;
	logic        wr_acc;
	logic        rd_acc;
	logic        sel_grp;
	logic        sel_ctrl;
	logic        sel_sts;
	logic        sel_msk;
	logic        wr_grp;
	logic        wr_ctrl;
	logic        wr_sts;
	logic        wr_msk;
	logic [1:0]  grp_idx;
	logic [15:0] grp_slots;
	logic [3:0]  wr_flags;
	logic [3:0]  wr_ens;
	logic [15:0] evt;
	logic [3:0]  grp_hit;

	// Group byte: four flags over four enables
	function automatic logic [7:0] grp_byte(input logic [15:0] f,
		input logic [15:0] e, input logic [1:0] g);
		logic [3:0] base;
		base = {g, 2'b00};
		return {f[base +: ifeb_pkg::GROUP_W], e[base +: ifeb_pkg::GROUP_W]};
	endfunction

	// Bank registers live at the four word offsets below the control word
	function automatic logic is_grp(input logic [ifeb_pkg::ADDR_W-1:0] a);
		return (a < ifeb_pkg::OFF_CTRL) && (a[1:0] == 2'b00);
	endfunction

	// One bit per group, set when any slot of that group is high
	function automatic logic [3:0] grp_any(input logic [15:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < ifeb_pkg::NUM_GROUPS; i++) begin
			r[i] = |(v[i*ifeb_pkg::GROUP_W +: ifeb_pkg::GROUP_W]);
		end
		return r;
	endfunction

	// Places a four-slot field into its group of the source vector
	function automatic logic [15:0] grp_place(input logic [3:0] v,
		input logic [1:0] g);
		logic [15:0] r;
		r = 16'h0000;
		r[{g, 2'b00} +: ifeb_pkg::GROUP_W] = v;
		return r;
	endfunction

	assign req       = avs_read_in | avs_write_in;
	assign wr_acc    = avs_write_in & done_q & avs_byteenable_in[0];
	assign rd_acc    = avs_read_in & ~done_q;
	assign sel_grp   = is_grp(avs_address_in);
	assign sel_ctrl  = (avs_address_in == ifeb_pkg::OFF_CTRL);
	assign sel_sts   = (avs_address_in == ifeb_pkg::OFF_STATUS);
	assign sel_msk   = (avs_address_in == ifeb_pkg::OFF_MASK);
	assign wr_grp    = wr_acc & sel_grp;
	assign wr_ctrl   = wr_acc & sel_ctrl;
	assign wr_sts    = wr_acc & sel_sts;
	assign wr_msk    = wr_acc & sel_msk;
	assign grp_idx   = avs_address_in[3:2];
	assign grp_slots = grp_place(4'hF, grp_idx);
	assign wr_flags  = avs_writedata_in[ifeb_pkg::FLAG_LSB +: ifeb_pkg::GROUP_W];
	assign wr_ens    = avs_writedata_in[ifeb_pkg::EN_LSB +: ifeb_pkg::GROUP_W];
	assign evt       = evt_in & IMPL;
	assign grp_hit   = grp_any(evt);

	// ************************************************
	// Bus handshake
	// ************************************************
	// One wait cycle per request: waitrequest drops in the second cycle
	always_comb begin
		done_d = req & ~done_q;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			done_q <= 1'b0;
		end else begin
			done_q <= done_d;
		end
	end

	// ************************************************
	// Request flags
	// ************************************************
	// Software writes a whole group; an event in the same cycle wins
	always_comb begin
		flag_d = flag_q;
		if (wr_grp) begin
			flag_d = (flag_q & ~grp_slots) |
				grp_place(wr_flags, grp_idx);
		end
		flag_d = (flag_d | evt) & IMPL;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			flag_q <= ifeb_pkg::SRC_RESET;
		end else begin
			flag_q <= flag_d;
		end
	end

	// ************************************************
	// Enables
	// ************************************************
	// Enables only gate the vector; flags are left alone
	always_comb begin
		en_d = en_q;
		if (wr_grp) begin
			en_d = (en_q & ~grp_slots) |
				grp_place(wr_ens, grp_idx);
		end
		en_d = en_d & IMPL;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			en_q <= ifeb_pkg::SRC_RESET;
		end else begin
			en_q <= en_d;
		end
	end

	// ************************************************
	// Global enable
	// ************************************************
	always_comb begin
		gen_d = gen_q;
		if (wr_ctrl) begin
			gen_d = avs_writedata_in[ifeb_pkg::GLOBAL_EN_POS];
		end
		// Service entry closes the gate even against a write
		if (svc_ack_in) begin
			gen_d = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			gen_q <= 1'b0;
		end else begin
			gen_q <= gen_d;
		end
	end

	// ************************************************
	// Status
	// ************************************************
	// Set wins over a same-cycle write-one-to-clear
	always_comb begin
		sts_d = sts_q;
		if (wr_sts) begin
			sts_d = sts_q & ~avs_writedata_in[3:0];
		end
		sts_d = sts_d | grp_hit;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sts_q <= ifeb_pkg::GRP_RESET;
		end else begin
			sts_q <= sts_d;
		end
	end

	// ************************************************
	// Mask
	// ************************************************
	always_comb begin
		msk_d = msk_q;
		if (wr_msk) begin
			msk_d = avs_writedata_in[3:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			msk_q <= ifeb_pkg::GRP_RESET;
		end else begin
			msk_q <= msk_d;
		end
	end

	// ************************************************
	// Read data
	// ************************************************
	// Unmapped and unaligned words read zero
	always_comb begin
		rdata_d = rdata_q;
		if (rd_acc) begin
			rdata_d = RD_ZERO;
			if (sel_grp) begin
				rdata_d[7:0] = grp_byte(flag_q, en_q, grp_idx);
			end else if (sel_ctrl) begin
				rdata_d[ifeb_pkg::GLOBAL_EN_POS] = gen_q;
			end else if (sel_sts) begin
				rdata_d[3:0] = sts_q;
			end else if (sel_msk) begin
				rdata_d[3:0] = msk_q;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rdata_q <= ifeb_pkg::RD_RESET;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ************************************************
	// Vector gating
	// ************************************************
	logic [15:0] gate_all;
	logic [15:0] vec_lvl;
	logic [3:0]  pend;

	// Flag, enable and global gate must all be high for a vector
	assign gate_all = {16{gen_q}};
	assign vec_lvl  = flag_q & en_q & gate_all;
	// Level interrupt from unmasked status groups
	assign pend     = sts_q & msk_q;

	// ************************************************
	// Outputs
	// ************************************************
	assign avs_readdata_out    = rdata_q;
	assign avs_waitrequest_out = req & ~done_q;
	assign vec_req_out = ifeb_pkg::ifeb_src_t'(vec_lvl);
	assign irq_out     = |pend;

endmodule

`default_nettype wire

// [verilog/ifeb_pkg.sv]
// Purpose: Constants and types for the interrupt flag/enable bank.
// Assumes: Avalon-MM slave with 32-bit data, byte addresses.
// Notes:   Each bank register holds four flags in 7..4, enables in 3..0.
//
// Contract
// - A flag reads 1 while its source has a pending request, else 0.
// - Timebase 1 flag is bit 7, timebase 0 flag bit 6 of timer register.
// - Converter flag bit 5, multi-function 1 flag bit 4, read/write.
// - Timer register enables bits 3..0: timebase1, timebase0, converter, mf1.
// - EEPROM flag bit 4, enable bit 0 of third register.
// - With UART option, UART flag bit 5 and enable bit 1.
// - Unimplemented bits read 0 and ignore writes.
// - Timer 0 comparator A flag bit 5, comparator P flag bit 4.
// - With second timer, its comparator A flag bit 7, P flag bit 6.
// - Timer enables: t1 A bit 3, t1 P bit 2, t0 A bit 1, t0 P bit 0.
// - Comparator enable gates its interrupt without touching the flag.
// - Flag sets on its event even when disabled; vector needs enable.
// - Global enable at 0 blocks every source; the code gates only vec_req_out with it, irq_out follows status and mask.
// - Service entry clears global enable; later events still set flags.

package ifeb_pkg;

	// ************************************************
	// Register map
	// ************************************************
	localparam int          ADDR_W       = 5;
	localparam logic [4:0]  OFF_TMR_CONV = 5'h00;
	localparam logic [4:0]  OFF_LV_SER   = 5'h04;
	localparam logic [4:0]  OFF_EEP_UART = 5'h08;
	localparam logic [4:0]  OFF_PTIMER   = 5'h0C;
	localparam logic [4:0]  OFF_CTRL     = 5'h10;
	localparam logic [4:0]  OFF_STATUS   = 5'h14;
	localparam logic [4:0]  OFF_MASK     = 5'h18;

	// ************************************************
	// Field layout and reset values
	// ************************************************
	localparam int          GROUP_W      = 4;
	localparam int          NUM_GROUPS   = 4;
	localparam int          FLAG_LSB     = 4;
	localparam int          EN_LSB       = 0;
	localparam int          GLOBAL_EN_POS = 0;
	localparam logic [15:0] SRC_RESET    = 16'h0000;
	localparam logic [3:0]  GRP_RESET    = 4'h0;
	localparam logic [31:0] RD_RESET     = 32'h0000_0000;

	// Slot order in each group, bit 3 down to 0:
	// tmr_conv: timebase1, timebase0, converter done, multi-function 1
	// lv_ser:   low voltage, sd comparator 1, serial module, ext pin 1
	// eep_uart: none, none, async serial, eeprom done
	// ptimer:   t1 cmp A, t1 cmp P, t0 cmp A, t0 cmp P
	typedef struct packed {
		logic [3:0] ptimer;
		logic [3:0] eep_uart;
		logic [3:0] lv_ser;
		logic [3:0] tmr_conv;
	} ifeb_src_t;

endpackage

// [verif/ifeb_bank_properties.sv]
// Purpose: Port assertions for the flag and enable bank.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to every bank instance.
`timescale 1ns/10ps
`default_nettype none
module ifeb_bank_props (
	input  wire logic                        clk_in,
	input  wire logic                        rst_n_in,
	input  wire logic [ifeb_pkg::ADDR_W-1:0] avs_address_in,
	input  wire logic                        avs_read_in,
	input  wire logic                        avs_write_in,
	input  wire logic [31:0]                 avs_readdata_out,
	input  wire logic                        avs_waitrequest_out,
	input  wire ifeb_pkg::ifeb_src_t         evt_in,
	input  wire logic                        svc_ack_in,
	input  wire ifeb_pkg::ifeb_src_t         vec_req_out,
	input  wire logic                        irq_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic req = avs_read_in | avs_write_in;
	wire logic done = req & !avs_waitrequest_out;
	wire logic rd_done = done & avs_read_in;
	sequence s_one_wait;
		avs_waitrequest_out ##1 !avs_waitrequest_out;
	endsequence
	AST_ONE_WAIT: assert property ($rose(req) |-> s_one_wait)
		else $error("bus answer not after one wait cycle");
	AST_DONE_ONCE: assert property (done |=> !done)
		else $error("waitrequest low for more than one cycle");
	AST_RST_QUIET: assert property ($rose(rst_n_in) |-> !irq_out && vec_req_out == 16'h0000)
		else $error("outputs active out of reset");
	AST_ACK_CLR: assert property (svc_ack_in |=> vec_req_out == 16'h0000)
		else $error("vector request after service entry");
	AST_VEC_CAUSE: assert property ($rose(|vec_req_out) |-> $past(|evt_in) || $past(done && avs_write_in))
		else $error("vector request without cause");
	AST_IRQ_CAUSE: assert property ($rose(irq_out) |-> $past(|evt_in) || $past(done && avs_write_in))
		else $error("interrupt without cause");
	AST_HIGH_ZERO: assert property (rd_done |-> avs_readdata_out[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	AST_EEP_GAPS: assert property (rd_done && avs_address_in == ifeb_pkg::OFF_EEP_UART |-> avs_readdata_out[7:6] == 2'h0 && avs_readdata_out[3:2] == 2'h0)
		else $error("unimplemented bits read nonzero");
	AST_UNMAPPED: assert property (rd_done && avs_address_in > 5'h18 |-> avs_readdata_out == 32'h0000_0000)
		else $error("unmapped read nonzero");
endmodule
bind ifeb_bank ifeb_bank_props u_props (.clk_in, .rst_n_in, .avs_address_in,
	.avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out,
	.evt_in, .svc_ack_in, .vec_req_out, .irq_out);
`default_nettype wire

// [verif/ifeb_far_model.sv]
// Purpose: Event sources and core service entry facing the bank.
// Assumes: Events and service ack are one-cycle pulses.
// Notes:   Acks only when told to take a pending vector.
`timescale 1ns/10ps
`default_nettype none
module ifeb_far_model (
	input  wire logic                clk_in,
	input  wire ifeb_pkg::ifeb_src_t fire_in,
	input  wire logic                take_in,
	input  wire ifeb_pkg::ifeb_src_t vec_req_in,
	output var ifeb_pkg::ifeb_src_t  evt_out,
	output logic                     svc_ack_out
);
	always_ff @(posedge clk_in) begin
		evt_out <= fire_in;
		svc_ack_out <= take_in && (|vec_req_in);
	end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Purpose: Self-checking bench for the flag and enable bank.
// Assumes: Default variant with UART and second periodic timer.
// Notes:   Bus tasks leave one idle cycle between requests.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic                clk = 1'b0;
	logic                rst_n = 1'b0;
	logic [4:0]          addr = 5'h00;
	logic                rd = 1'b0;
	logic                wr = 1'b0;
	logic [31:0]         wdata = 32'h0000_0000;
	logic [31:0]         rdata;
	logic [31:0]         got;
	logic                waitreq;
	logic                take = 1'b0;
	logic [3:0]          be = 4'hF;
	logic                be_off = 1'b0;
	logic                irq;
	logic                ack;
	ifeb_pkg::ifeb_src_t fire = 16'h0000;
	ifeb_pkg::ifeb_src_t evt;
	ifeb_pkg::ifeb_src_t vec;
	logic [7:0]          full [4] = '{8'hFF, 8'hFF, 8'h33, 8'hFF};
	int                  n_errors = 0;
	int                  cmp_count = 0;
	always #20 clk = ~clk;
	ifeb_bank dut (.clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(be), .avs_readdata_out(rdata),
		.avs_waitrequest_out(waitreq), .evt_in(evt), .svc_ack_in(ack),
		.vec_req_out(vec), .irq_out(irq));
	ifeb_far_model far (.clk_in(clk), .fire_in(fire), .take_in(take),
		.vec_req_in(vec), .evt_out(evt), .svc_ack_out(ack));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("Mismatches %0d, compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int i;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {24'h00_0000, d};
		be <= be_off ? 4'h0 : 4'hF;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (waitreq === 1'b0) break;
		end
		if (i == 50) begin
			n_errors++;
			final_report();
		end
		got = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(got, {24'h00_0000, exp});
	endtask
	task automatic pulse_fire(input logic [15:0] p);
		@(posedge clk);
		fire <= p;
		@(posedge clk);
		fire <= 16'h0000;
		repeat (2) @(posedge clk);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 8; k++) rdchk(5'(k * 4), 8'h00);
		for (int k = 0; k < 4; k++) bus(1'b1, 5'(k * 4), 8'hFF);
		bus(1'b1, 5'h1C, 8'hFF);
		for (int k = 0; k < 4; k++) rdchk(5'(k * 4), full[k]);
		rdchk(5'h1C, 8'h00);
		for (int k = 0; k < 4; k++) bus(1'b1, 5'(k * 4), 8'h00);
		pulse_fire(16'hFFFF);
		for (int k = 0; k < 4; k++) rdchk(5'(k * 4), full[k] & 8'hF0);
		check({16'h0000, vec}, 32'h0000_0000);
		rdchk(ifeb_pkg::OFF_STATUS, 8'h0F);
		bus(1'b1, ifeb_pkg::OFF_MASK, 8'h0F);
		check({31'h0, irq}, 32'h0000_0001);
		be_off = 1'b1;
		bus(1'b1, ifeb_pkg::OFF_MASK, 8'h00);
		be_off = 1'b0;
		rdchk(ifeb_pkg::OFF_MASK, 8'h0F);
		for (int k = 0; k < 4; k++) bus(1'b1, 5'(k * 4), full[k]);
		check({16'h0000, vec}, 32'h0000_0000);
		bus(1'b1, ifeb_pkg::OFF_CTRL, 8'h01);
		check({16'h0000, vec}, 32'h0000_F3FF);
		bus(1'b1, ifeb_pkg::OFF_PTIMER, 8'hF0);
		check({16'h0000, vec}, 32'h0000_03FF);
		rdchk(ifeb_pkg::OFF_PTIMER, 8'hF0);
		@(posedge clk);
		take <= 1'b1;
		@(posedge clk);
		take <= 1'b0;
		bus(1'b1, ifeb_pkg::OFF_TMR_CONV, 8'h0F);
		pulse_fire(16'h000F);
		check({16'h0000, vec}, 32'h0000_0000);
		rdchk(ifeb_pkg::OFF_CTRL, 8'h00);
		rdchk(ifeb_pkg::OFF_TMR_CONV, 8'hFF);
		bus(1'b1, ifeb_pkg::OFF_STATUS, 8'h0F);
		rdchk(ifeb_pkg::OFF_STATUS, 8'h00);
		check({31'h0, irq}, 32'h0000_0000);
		final_report();
	end
endmodule
`default_nettype wire
